// [shared/cpu_tail_pkg.sv]
// Opcodes, cycle counts, flag positions and reset values of the CPU tail
package cpu_tail_pkg;

  // ==========================================================================
  // Opcodes (prefix byte selects the second index register)
  localparam logic [7:0] OP_PREFIX_Y             = 8'h18;
  localparam logic [7:0] OP_SUB_DOUBLE_ACC_IMM   = 8'h83;
  localparam logic [7:0] OP_SUB_DOUBLE_ACC_DIR   = 8'h93;
  localparam logic [7:0] OP_ACC_TO_FLAGS         = 8'h06;
  localparam logic [7:0] OP_FLAGS_TO_ACC         = 8'h07;
  localparam logic [7:0] OP_COPY_FIRST_TO_SECOND = 8'h16;
  localparam logic [7:0] OP_COPY_SECOND_TO_FIRST = 8'h17;
  localparam logic [7:0] OP_TEST_INCREMENT       = 8'h00;
  localparam logic [7:0] OP_MEM_ZERO_CHECK_EXT   = 8'h7D;
  localparam logic [7:0] OP_MEM_ZERO_CHECK_IDX   = 8'h6D;
  localparam logic [7:0] OP_FIRST_ACC_ZERO_CHECK = 8'h4D;
  localparam logic [7:0] OP_SECOND_ACC_ZERO_CHK  = 8'h5D;
  localparam logic [7:0] OP_STACK_TO_INDEX       = 8'h30;
  localparam logic [7:0] OP_INDEX_TO_STACK       = 8'h35;
  localparam logic [7:0] OP_IDLE_UNTIL_IRQ       = 8'h3E;
  localparam logic [7:0] OP_SOFT_TRAP            = 8'h3F;
  localparam logic [7:0] OP_SWAP_DOUBLE_INDEX    = 8'h8F;
  localparam logic [7:0] OP_BRANCH_ALWAYS        = 8'h20;

  // ==========================================================================
  // Cycle totals from opcode fetch, without the prefix cycle
  localparam logic [3:0] CYC_SUB_IMM    = 4'h4;
  localparam logic [3:0] CYC_SUB_DIR    = 4'h5;
  localparam logic [3:0] CYC_INHERENT   = 4'h2;
  localparam logic [3:0] CYC_MEM_CHECK  = 4'h6;
  localparam logic [3:0] CYC_TRANSFER   = 4'h3;
  localparam logic [3:0] CYC_BRANCH     = 4'h3;
  localparam logic [3:0] CYC_TRAP       = 4'hE;
  // Step numbers inside the stacking sequences
  localparam logic [3:0] STEP_STACK_FIRST = 4'h2;
  localparam logic [3:0] STEP_STACK_LAST  = 4'hA;
  localparam logic [3:0] STEP_WAIT_POINT  = 4'hB;
  localparam logic [3:0] STEP_VEC_HI      = 4'hC;
  localparam logic [3:0] STEP_VEC_LO      = 4'hD;

  // ==========================================================================
  // Vectors and reset values
  localparam logic [15:0] VEC_SOFT_TRAP = 16'hFFF6;
  localparam logic [15:0] VEC_IRQ       = 16'hFFF2;
  localparam logic [15:0] RESET_PC      = 16'h0000;
  localparam logic [15:0] RESET_SP      = 16'h00FF;
  localparam logic [7:0]  RESET_FLAGS   = 8'hD0;

  // ==========================================================================
  // Condition flag bit positions
  localparam int FLAG_S = 7;
  localparam int FLAG_X = 6;
  localparam int FLAG_I = 4;
  localparam int FLAG_N = 3;
  localparam int FLAG_Z = 2;
  localparam int FLAG_V = 1;
  localparam int FLAG_C = 0;

  typedef enum logic [1:0] {
    PH_FETCH = 2'b00,
    PH_EXEC  = 2'b01,
    PH_WAIT  = 2'b10,
    PH_TEST  = 2'b11
  } phase_e;

  typedef enum logic [1:0] {
    EA_DIRECT   = 2'b00,
    EA_INDEXED  = 2'b01,
    EA_RELATIVE = 2'b10
  } ea_mode_e;

  // Total cycles of an opcode; unknown opcodes run as 2-cycle no-ops
  function automatic logic [3:0] cycleCount(input logic [7:0] op);
    unique case (op)
      OP_SUB_DOUBLE_ACC_IMM:                        return CYC_SUB_IMM;
      OP_SUB_DOUBLE_ACC_DIR:                        return CYC_SUB_DIR;
      OP_MEM_ZERO_CHECK_EXT, OP_MEM_ZERO_CHECK_IDX: return CYC_MEM_CHECK;
      OP_STACK_TO_INDEX, OP_INDEX_TO_STACK,
      OP_SWAP_DOUBLE_INDEX:                         return CYC_TRANSFER;
      OP_BRANCH_ALWAYS:                             return CYC_BRANCH;
      OP_SOFT_TRAP, OP_IDLE_UNTIL_IRQ:              return CYC_TRAP;
      default:                                      return CYC_INHERENT;
    endcase
  endfunction : cycleCount

endpackage : cpu_tail_pkg

// [shared/alu_if.sv]
// Address and subtract arithmetic shared between core and helper
`timescale 1ns/1ps
`default_nettype none
interface alu_if;
  import cpu_tail_pkg::*;
  ea_mode_e    eaMode;
  logic [7:0]  offByte;
  logic [15:0] baseAddr;
  logic [15:0] effAddr;
  logic [15:0] minuend;
  logic [15:0] subtrahend;
  logic [15:0] diff;
  logic [3:0]  subFlags;   // N Z V C

  modport core (output eaMode, offByte, baseAddr, minuend, subtrahend,
                input  effAddr, diff, subFlags);
  modport alu  (input  eaMode, offByte, baseAddr, minuend, subtrahend,
                output effAddr, diff, subFlags);
endinterface : alu_if
`default_nettype wire

// [rtl/addr_alu.sv]
// Effective address forming and 16-bit subtract for the CPU tail
`timescale 1ns/1ps
`default_nettype none
module addr_alu
  import cpu_tail_pkg::*;
(
  // Arithmetic operands and results
  alu_if.alu ifc
);

  logic [16:0] wide;

  // ==========================================================================
  // Effective address
  always_comb begin
    unique case (ifc.eaMode)
      EA_INDEXED:  ifc.effAddr = ifc.baseAddr + {8'h00, ifc.offByte};
      EA_RELATIVE: ifc.effAddr = ifc.baseAddr
                                 + {{8{ifc.offByte[7]}}, ifc.offByte};
      default:     ifc.effAddr = {8'h00, ifc.offByte};
    endcase
  end

  // ==========================================================================
  // Double accumulator minus memory word, borrow lands in bit 16
  always_comb begin
    wide = {1'b0, ifc.minuend} - {1'b0, ifc.subtrahend};
    ifc.diff = wide[15:0];
    ifc.subFlags[3] = wide[15];
    ifc.subFlags[2] = (wide[15:0] == 16'h0000);
    ifc.subFlags[1] = (ifc.minuend[15] & ~ifc.subtrahend[15] & ~wide[15])
                    | (~ifc.minuend[15] & ifc.subtrahend[15] & wide[15]);
    ifc.subFlags[0] = wide[16];
  end

endmodule : addr_alu
`default_nettype wire

// [rtl/cpu_opcode_decode_tail.sv]
// Sequencer and datapath for the tail of the CPU instruction set
//
// Operation
// - Double accumulator minus 16-bit word, high byte first; 83 4, 93 5
// - Opcode 06 copies first accumulator into flags in 2 cycles
// - A clear-only flag may fall to zero but never rises
// - Opcode 00 in test mode increments address forever until reset
// - Opcode 07 copies flags into first accumulator, flags unchanged
// - Memory zero check sets N Z, clears V C; 7D 6D 6, 18 6D 7
// - Opcode 4D tests first accumulator, N Z updated, V C cleared
// - Opcode 5D tests second accumulator, N Z updated, V C cleared
// - Opcode 30 loads first index with stack pointer plus one, 3 cycles
// - Prefixed 30 loads second index with stack pointer plus one
// - Opcode 35 loads stack pointer with first index minus one
// - Prefixed 35 loads stack pointer with second index minus one
// - Idle opcode 3E stacks in 12, waits n, vectors in 2
// - Direct address is the operand byte with high byte zero
// - Indexed address is index plus unsigned 8-bit offset
// - Branch target is next address plus sign-extended offset
`timescale 1ns/1ps
`default_nettype none
module cpu_opcode_decode_tail
  import cpu_tail_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // Memory bus, one transfer per clock
  output logic [15:0]      memAddr,
  output logic [7:0]       memWrData,
  output logic             memWrite,
  input  wire logic [7:0]  memRdData,
  // Mode and interrupt
  input  wire logic        testMode,
  input  wire logic        irqReq,
  // Status
  output logic             fetchCycle,
  output logic             idling,
  output logic             testRunning,
  // Programmer-visible registers
  output logic [7:0]       accFirst,
  output logic [7:0]       accSecond,
  output logic [15:0]      indexOne,
  output logic [15:0]      indexTwo,
  output logic [15:0]      stackPtr,
  output logic [15:0]      progCount,
  output logic [7:0]       conditionFlags
);

  // ==========================================================================
  // State
  typedef struct packed {
    phase_e      phase;
    logic [7:0]  op;
    logic        pre;
    logic [3:0]  step;
    logic [7:0]  a;
    logic [7:0]  b;
    logic [7:0]  flags;
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] sp;
    logic [15:0] pc;
    logic [15:0] ea;
    logic [15:0] mem;
    logic [15:0] addr;
    logic [7:0]  dout;
    logic        we;
    logic        fetchCyc;
    logic        idle;
    logic        testRun;
  } core_s;

  core_s r_r;
  core_s r_nxt;
  alu_if ifc ();

  // ==========================================================================
  // Functions
  // N and Z from a byte, V cleared, the rest kept
  function automatic logic [7:0] nzClearV(input logic [7:0] f,
                                          input logic [7:0] v);
    logic [7:0] o;
    o = f;
    o[FLAG_N] = v[7];
    o[FLAG_Z] = (v == 8'h00);
    o[FLAG_V] = 1'b0;
    return o;
  endfunction : nzClearV

  // Zero check: as above, and carry cleared as well
  function automatic logic [7:0] zeroCheck(input logic [7:0] f,
                                           input logic [7:0] v);
    logic [7:0] o;
    o = nzClearV(f, v);
    o[FLAG_C] = 1'b0;
    return o;
  endfunction : zeroCheck

  // Byte pushed at a given stacking position, return address first
  function automatic logic [7:0] stackByte(input core_s s,
                                           input logic [3:0] idx);
    unique case (idx)
      4'h0:    return s.pc[7:0];
      4'h1:    return s.pc[15:8];
      4'h2:    return s.y[7:0];
      4'h3:    return s.y[15:8];
      4'h4:    return s.x[7:0];
      4'h5:    return s.x[15:8];
      4'h6:    return s.a;
      4'h7:    return s.b;
      default: return s.flags;
    endcase
  endfunction : stackByte

  // ==========================================================================
  // Arithmetic helper; operands from registered state and the read data only, to avoid loops
  assign ifc.eaMode   = (r_r.op == OP_BRANCH_ALWAYS)      ? EA_RELATIVE :
                        (r_r.op == OP_MEM_ZERO_CHECK_IDX) ? EA_INDEXED  :
                                                            EA_DIRECT;
  assign ifc.offByte  = (ifc.eaMode == EA_DIRECT) ? memRdData : r_r.ea[7:0];
  assign ifc.baseAddr = (ifc.eaMode == EA_RELATIVE) ? r_r.pc :
                        (r_r.pre ? r_r.y : r_r.x);
  assign ifc.minuend    = {r_r.a, r_r.b};
  assign ifc.subtrahend = r_r.mem;

  addr_alu u_alu (
    .ifc (ifc.alu)
  );

  // ==========================================================================
  // Next state: sequencing, datapath, then the bus for the next cycle
  always_comb begin
    r_nxt          = r_r;
    r_nxt.we       = 1'b0;
    r_nxt.dout     = 8'h00;
    r_nxt.fetchCyc = 1'b0;

    unique case (r_r.phase)
      // Opcode fetch; a prefix byte costs one extra cycle
      PH_FETCH: begin
        r_nxt.pc = r_r.pc + 16'h0001;
        if (memRdData == OP_PREFIX_Y && !r_r.pre) begin
          r_nxt.pre = 1'b1;
        end else begin
          r_nxt.op   = memRdData;
          r_nxt.step = 4'h1;
          if (memRdData == OP_TEST_INCREMENT && testMode) begin
            r_nxt.phase   = PH_TEST;
            r_nxt.testRun = 1'b1;
          end else if (cycleCount(memRdData) == CYC_INHERENT
                       && 1'b0) begin
            r_nxt.phase = PH_FETCH;
          end else begin
            r_nxt.phase = PH_EXEC;
          end
        end
      end

      PH_EXEC: begin
        r_nxt.step = r_r.step + 4'h1;
        // Last step of the instruction hands back to fetch
        if (r_r.step == cycleCount(r_r.op) - 4'h1) begin
          r_nxt.phase = PH_FETCH;
          r_nxt.pre   = 1'b0;
          r_nxt.step  = 4'h0;
        end
        unique case (r_r.op)
          OP_SUB_DOUBLE_ACC_IMM: begin
            if (r_r.step == 4'h1) begin
              r_nxt.mem[15:8] = memRdData;
              r_nxt.pc        = r_r.pc + 16'h0001;
            end else if (r_r.step == 4'h2) begin
              r_nxt.mem[7:0] = memRdData;
              r_nxt.pc       = r_r.pc + 16'h0001;
            end else begin
              {r_nxt.a, r_nxt.b} = ifc.diff;
              r_nxt.flags[3:0]   = ifc.subFlags;
            end
          end
          OP_SUB_DOUBLE_ACC_DIR: begin
            if (r_r.step == 4'h1) begin
              r_nxt.ea = ifc.effAddr;
              r_nxt.pc = r_r.pc + 16'h0001;
            end else if (r_r.step == 4'h2) begin
              r_nxt.mem[15:8] = memRdData;
            end else if (r_r.step == 4'h3) begin
              r_nxt.mem[7:0] = memRdData;
            end else begin
              {r_nxt.a, r_nxt.b} = ifc.diff;
              r_nxt.flags[3:0]   = ifc.subFlags;
            end
          end
          OP_ACC_TO_FLAGS: begin
            // Mask flag X may only be cleared from the accumulator
            r_nxt.flags         = r_r.a;
            r_nxt.flags[FLAG_X] = r_r.flags[FLAG_X] & r_r.a[FLAG_X];
          end
          OP_FLAGS_TO_ACC: begin
            r_nxt.a = r_r.flags;
          end
          OP_COPY_FIRST_TO_SECOND: begin
            r_nxt.b     = r_r.a;
            r_nxt.flags = nzClearV(r_r.flags, r_r.a);
          end
          OP_COPY_SECOND_TO_FIRST: begin
            r_nxt.a     = r_r.b;
            r_nxt.flags = nzClearV(r_r.flags, r_r.b);
          end
          OP_FIRST_ACC_ZERO_CHECK: begin
            r_nxt.flags = zeroCheck(r_r.flags, r_r.a);
          end
          OP_SECOND_ACC_ZERO_CHK: begin
            r_nxt.flags = zeroCheck(r_r.flags, r_r.b);
          end
          OP_MEM_ZERO_CHECK_EXT: begin
            if (r_r.step == 4'h1) begin
              r_nxt.ea[15:8] = memRdData;
              r_nxt.pc       = r_r.pc + 16'h0001;
            end else if (r_r.step == 4'h2) begin
              r_nxt.ea[7:0] = memRdData;
              r_nxt.pc      = r_r.pc + 16'h0001;
            end else if (r_r.step == 4'h3) begin
              r_nxt.mem[7:0] = memRdData;
            end else if (r_r.step == 4'h5) begin
              r_nxt.flags = zeroCheck(r_r.flags, r_r.mem[7:0]);
            end
          end
          OP_MEM_ZERO_CHECK_IDX: begin
            if (r_r.step == 4'h1) begin
              r_nxt.ea = {8'h00, memRdData};
              r_nxt.pc = r_r.pc + 16'h0001;
            end else if (r_r.step == 4'h2) begin
              r_nxt.ea = ifc.effAddr;
            end else if (r_r.step == 4'h3) begin
              r_nxt.mem[7:0] = memRdData;
            end else if (r_r.step == 4'h5) begin
              r_nxt.flags = zeroCheck(r_r.flags, r_r.mem[7:0]);
            end
          end
          OP_STACK_TO_INDEX: begin
            if (r_r.step == 4'h2) begin
              if (r_r.pre) begin
                r_nxt.y = r_r.sp + 16'h0001;
              end else begin
                r_nxt.x = r_r.sp + 16'h0001;
              end
            end
          end
          OP_INDEX_TO_STACK: begin
            if (r_r.step == 4'h2) begin
              if (r_r.pre) begin
                r_nxt.sp = r_r.y - 16'h0001;
              end else begin
                r_nxt.sp = r_r.x - 16'h0001;
              end
            end
          end
          OP_SWAP_DOUBLE_INDEX: begin
            if (r_r.step == 4'h2) begin
              if (r_r.pre) begin
                {r_nxt.a, r_nxt.b} = r_r.y;
                r_nxt.y            = {r_r.a, r_r.b};
              end else begin
                {r_nxt.a, r_nxt.b} = r_r.x;
                r_nxt.x            = {r_r.a, r_r.b};
              end
            end
          end
          OP_BRANCH_ALWAYS: begin
            if (r_r.step == 4'h1) begin
              r_nxt.ea = {8'h00, memRdData};
              r_nxt.pc = r_r.pc + 16'h0001;
            end else begin
              r_nxt.pc = ifc.effAddr;
            end
          end
          OP_SOFT_TRAP, OP_IDLE_UNTIL_IRQ: begin
            if (r_r.step >= STEP_STACK_FIRST
                && r_r.step <= STEP_STACK_LAST) begin
              r_nxt.sp = r_r.sp - 16'h0001;
            end else if (r_r.step == STEP_WAIT_POINT) begin
              r_nxt.flags[FLAG_I] = 1'b1;
              // Idle ends at once if a request is already recognised
              if (r_r.op == OP_IDLE_UNTIL_IRQ
                  && !(irqReq && !r_r.flags[FLAG_I])) begin
                r_nxt.phase         = PH_WAIT;
                r_nxt.idle          = 1'b1;
                r_nxt.flags[FLAG_I] = r_r.flags[FLAG_I];
              end
            end else if (r_r.step == STEP_VEC_HI) begin
              r_nxt.mem[15:8] = memRdData;
            end else if (r_r.step == STEP_VEC_LO) begin
              r_nxt.pc = {r_r.mem[15:8], memRdData};
            end
          end
          default: begin
            // Other opcodes idle through their cycles
          end
        endcase
      end

      // Whole idle cycles until an unmasked request arrives
      PH_WAIT: begin
        if (irqReq && !r_r.flags[FLAG_I]) begin
          r_nxt.phase         = PH_EXEC;
          r_nxt.step          = STEP_VEC_HI;
          r_nxt.idle          = 1'b0;
          r_nxt.flags[FLAG_I] = 1'b1;
        end
      end

      // No way out but reset
      PH_TEST: begin
        r_nxt.testRun = 1'b1;
      end
    endcase

    // Bus for the coming cycle; internal cycles show the program counter
    r_nxt.addr     = r_nxt.pc;
    r_nxt.fetchCyc = (r_nxt.phase == PH_FETCH);
    if (r_nxt.phase == PH_TEST) begin
      r_nxt.addr = (r_r.phase == PH_TEST) ? r_r.addr + 16'h0001
                                          : r_nxt.pc;
    end else if (r_nxt.phase == PH_EXEC) begin
      unique case (r_nxt.op)
        OP_SUB_DOUBLE_ACC_DIR: begin
          if (r_nxt.step == 4'h2) begin
            r_nxt.addr = r_nxt.ea;
          end else if (r_nxt.step == 4'h3) begin
            r_nxt.addr = r_nxt.ea + 16'h0001;
          end
        end
        OP_MEM_ZERO_CHECK_EXT, OP_MEM_ZERO_CHECK_IDX: begin
          if (r_nxt.step == 4'h3) begin
            r_nxt.addr = r_nxt.ea;
          end
        end
        OP_SOFT_TRAP, OP_IDLE_UNTIL_IRQ: begin
          if (r_nxt.step >= STEP_STACK_FIRST
              && r_nxt.step <= STEP_STACK_LAST) begin
            r_nxt.addr = r_nxt.sp;
            r_nxt.we   = 1'b1;
            r_nxt.dout = stackByte(r_nxt, r_nxt.step - STEP_STACK_FIRST);
          end else if (r_nxt.step == STEP_VEC_HI) begin
            r_nxt.addr = (r_nxt.op == OP_SOFT_TRAP) ? VEC_SOFT_TRAP
                                                    : VEC_IRQ;
          end else if (r_nxt.step == STEP_VEC_LO) begin
            r_nxt.addr = ((r_nxt.op == OP_SOFT_TRAP) ? VEC_SOFT_TRAP
                                                     : VEC_IRQ) + 16'h0001;
          end
        end
        default: begin
          r_nxt.addr = r_nxt.pc;
        end
      endcase
    end
  end

  // ==========================================================================
  // State register; reset starts an opcode fetch at the reset address
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      r_r          <= '0;
      r_r.pc       <= RESET_PC;
      r_r.addr     <= RESET_PC;
      r_r.sp       <= RESET_SP;
      r_r.flags    <= RESET_FLAGS;
      r_r.fetchCyc <= 1'b1;
    end else begin
      r_r <= r_nxt;
    end
  end

  // ==========================================================================
  // Outputs straight from the state register
  assign memAddr        = r_r.addr;
  assign memWrData      = r_r.dout;
  assign memWrite       = r_r.we;
  assign fetchCycle     = r_r.fetchCyc;
  assign idling         = r_r.idle;
  assign testRunning    = r_r.testRun;
  assign accFirst       = r_r.a;
  assign accSecond      = r_r.b;
  assign indexOne       = r_r.x;
  assign indexTwo       = r_r.y;
  assign stackPtr       = r_r.sp;
  assign progCount      = r_r.pc;
  assign conditionFlags = r_r.flags;

endmodule : cpu_opcode_decode_tail
`default_nettype wire

// [sim/cpu_tail_props.sv]
// Assertion checker for the CPU tail sequencer, bound to its top
`timescale 1ns/1ps
`default_nettype none
module cpu_tail_props
  import cpu_tail_pkg::*;
(
  // Clock, reset and status bits
  input wire logic        clk_sys, reset, irqReq, fetchCycle,
  input wire logic        idling, testRunning,
  // Bytes and words
  input wire logic [7:0]  memRdData, accFirst, conditionFlags,
  input wire logic [15:0] memAddr, indexOne, stackPtr
);
  // ==========================================================
  // Opcode after a prefix byte kept out of the plain-opcode checks
  logic prefix_r;
  logic opNow;
  always_ff @(posedge clk_sys) begin
    prefix_r <= !reset && fetchCycle && memRdData == OP_PREFIX_Y;
  end
  assign opNow = fetchCycle && !prefix_r;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Results and timing; opcode checks counted from the fetch edge, wake and test count from the cycle before
  property p_tap; opNow && memRdData == OP_ACC_TO_FLAGS |-> ##2 fetchCycle
    && conditionFlags == (accFirst & {1'b1, $past(conditionFlags[6], 2),
    6'h3F}); endproperty
  a_tap: assert property (p_tap) else $error("flags copy");
  property p_xKeep; !$rose(conditionFlags[FLAG_X]); endproperty
  a_xKeep: assert property (p_xKeep) else $error("X flag rose");
  property p_inc; testRunning |=> testRunning
    && memAddr == $past(memAddr) + 16'h0001; endproperty
  a_inc: assert property (p_inc) else $error("test increment");
  property p_tpa; opNow && memRdData == OP_FLAGS_TO_ACC |-> ##2 fetchCycle
    && accFirst == conditionFlags
    && conditionFlags == $past(conditionFlags, 2); endproperty
  a_tpa: assert property (p_tpa) else $error("flags read");
  property p_first_acc_zero_check; opNow && memRdData == OP_FIRST_ACC_ZERO_CHECK |-> ##2
    fetchCycle && conditionFlags[3:0] == {accFirst[7], accFirst == 8'h00,
    2'b00}; endproperty
  a_first_acc_zero_check: assert property (p_first_acc_zero_check) else $error("acc test");
  property p_tsx; opNow && memRdData == OP_STACK_TO_INDEX |-> ##3 fetchCycle
    && indexOne == $past(stackPtr, 3) + 16'h0001; endproperty
  a_tsx: assert property (p_tsx) else $error("stack to index");
  property p_wake; idling && irqReq && !conditionFlags[FLAG_I] |=>
    memAddr == VEC_IRQ ##1 memAddr == 16'hFFF3 ##1 fetchCycle; endproperty
  a_wake: assert property (p_wake) else $error("wake vector");
  property p_trap; opNow && memRdData == OP_SOFT_TRAP |-> ##12 memAddr ==
    VEC_SOFT_TRAP ##2 fetchCycle && conditionFlags[FLAG_I]; endproperty
  a_trap: assert property (p_trap) else $error("trap vector");
endmodule : cpu_tail_props
bind cpu_opcode_decode_tail cpu_tail_props i_cpu_tail_props (.*);
`default_nettype wire

// [sim/cpu_tail_mem.sv]
// Zero-wait program and data memory on the CPU bus
`timescale 1ns/1ps
`default_nettype none
module cpu_tail_mem (
  // Bus from the CPU
  input  wire logic        clk_sys,
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  wrData,
  input  wire logic        wrEn,
  output logic [7:0]       rdData
);
  logic [7:0] mem [0:65535];
  // Read answers in the same cycle, as the bus has no wait states
  assign rdData = mem[addr];
  always @(posedge clk_sys) begin
    if (wrEn) begin
      mem[addr] <= wrData;
    end
  end
endmodule : cpu_tail_mem
`default_nettype wire

// [sim/cpu_opcode_decode_tail_tb.sv]
// Self-checking testbench for the CPU tail sequencer
`timescale 1ns/1ps
`default_nettype none
module cpu_opcode_decode_tail_tb;
  import cpu_tail_pkg::*;
  // ==========================================================
  // Design signals and bench state
  logic        clk_sys, reset, testMode, irqReq, memWrite;
  logic        fetchCycle, idling, testRunning;
  logic [7:0]  memWrData, memRdData, accFirst, accSecond, conditionFlags;
  logic [15:0] memAddr, indexOne, indexTwo, stackPtr, progCount;
  logic [7:0]  prog [$];
  int          fails, checked, cyc;
  cpu_opcode_decode_tail i_cpu_opcode_decode_tail (.*);
  cpu_tail_mem i_cpu_tail_mem (.clk_sys(clk_sys), .addr(memAddr),
    .wrData(memWrData), .wrEn(memWrite), .rdData(memRdData));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic complete_run;
    $display("Counts: %0d checked, %0d mismatched", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run
  task automatic cmp(string what, logic [15:0] exp, logic [15:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  // Zeroed memory keeps vector high bytes at 00; reset held 20 cycles
  task automatic boot;
    reset = 1'b1;
    for (int i = 0; i < 65536; i++) begin
      i_cpu_tail_mem.mem[i] = 8'h00;
    end
    foreach (prog[i]) begin
      i_cpu_tail_mem.mem[i] = prog[i];
    end
    i_cpu_tail_mem.mem[16'hFFF3] = 8'h80;
    i_cpu_tail_mem.mem[16'hFFF7] = 8'h90;
    i_cpu_tail_mem.mem[16'h0040] = 8'h12;
    i_cpu_tail_mem.mem[16'h0041] = 8'h34;
    i_cpu_tail_mem.mem[16'h0080] = OP_SOFT_TRAP;
    repeat (20) @(negedge clk_sys);
    reset = 1'b0;
  endtask : boot
  // Step to the opcode fetch at a, counting cycles, bounded
  task automatic runTo(logic [15:0] a);
    cyc = 0;
    while (!(fetchCycle === 1'b1 && memAddr === a)) begin
      @(negedge clk_sys);
      cyc++;
      if (cyc > 300) begin
        fails++;
        complete_run();
      end
    end
  endtask : runTo
  task automatic testFlow;
    prog = '{8'h30, 8'h83, 8'h12, 8'h34, 8'h8F, 8'h35, 8'h18, 8'h30,
             8'h06, 8'h4D, 8'h07, 8'h5D, 8'h93, 8'h40, 8'h3E};
    boot();
    runTo(16'h000E);
    cmp("cycles", 16'h001E, 16'(cyc));
    cmp("accFirst", 16'h00ED, {8'h00, accFirst});
    cmp("accSecond", 16'h00CC, {8'h00, accSecond});
    cmp("indexOne", 16'hEDCC, indexOne);
    cmp("indexTwo", 16'hEDCC, indexTwo);
    cmp("stackPtr", 16'hEDCB, stackPtr);
    cmp("flags", 16'h0009, {8'h00, conditionFlags});
    repeat (12) @(negedge clk_sys);
    cmp("idling", 16'h0001, {15'h0000, idling});
    repeat (4) @(negedge clk_sys);
    irqReq = 1'b1;
    runTo(16'h0080);
    irqReq = 1'b0;
    cmp("wakeCycles", 16'h0003, 16'(cyc));
    cmp("retLow", 16'h000F, {8'h00, i_cpu_tail_mem.mem[16'hEDCB]});
    cmp("savedFlags", 16'h0009, {8'h00, i_cpu_tail_mem.mem[16'hEDC3]});
    runTo(16'h0090);
    cmp("trapCycles", 16'h000E, 16'(cyc));
    cmp("trapRet", 16'h0081, {8'h00, i_cpu_tail_mem.mem[16'hEDC2]});
    $display("testFlow done");
  endtask : testFlow
  // Copy, prefixed swap and stack load, indexed test, branches both ways
  task automatic testAddr;
    prog = '{8'h83, 8'hFF, 8'h00, 8'h16, 8'h18, 8'h8F, 8'h18, 8'h35, 8'h18,
             8'h6D, 8'hFF, 8'h20, 8'h03, 8'h00, 8'h5D, 8'h00, 8'h20, 8'hFC};
    boot();
    // Only the unsigned sum 0101 + FF reaches this byte
    i_cpu_tail_mem.mem[16'h0200] = 8'h80;
    runTo(16'h000B);
    cmp("addrCycles", 16'h0015, 16'(cyc));
    cmp("indexTwo", 16'h0101, indexTwo);
    cmp("stackPtr", 16'h0100, stackPtr);
    cmp("flags", 16'h00D8, {8'h00, conditionFlags});
    runTo(16'h000E);
    cmp("branchCycles", 16'h0006, 16'(cyc));
    cmp("progCount", 16'h000E, progCount);
    runTo(16'h000F);
    cmp("flags", 16'h00D4, {8'h00, conditionFlags});
    $display("testAddr done");
  endtask : testAddr
  // Opcode 00 is a no-op outside test mode, endless count inside it
  task automatic testIncrement;
    prog = '{8'h00};
    boot();
    runTo(16'h0001);
    cmp("noOpCycles", 16'h0002, 16'(cyc));
    testMode = 1'b1;
    boot();
    repeat (10) @(negedge clk_sys);
    cmp("incAddr", 16'h000A, memAddr);
    cmp("running", 16'h0001, {15'h0000, testRunning});
    $display("testIncrement done");
  endtask : testIncrement
  initial begin
    reset = 1'b1;
    testMode = 1'b0;
    irqReq = 1'b0;
    testFlow();
    testAddr();
    testIncrement();
    complete_run();
  end
endmodule : cpu_opcode_decode_tail_tb
`default_nettype wire
